// File: rtl/cpfc_defines.svh
/*
 Constants of the program-flow core: vectors, widths, opcodes,
 memory map and reset values.
 Assumes it is included by bare name by every file that needs it.
*/
`ifndef CPFC_DEFINES_SVH
`define CPFC_DEFINES_SVH

// ==========================================================
// Widths
`define CPFC_IP_W        10
`define CPFC_STK_DEPTH   4
`define CPFC_RAM_WORDS   64
`define CPFC_DADDR_W     7

// ==========================================================
// Vectors
`define CPFC_VEC_RESET   10'h000
`define CPFC_VEC_PORTA   10'h014
`define CPFC_VEC_PREDIV  10'h01c
`define CPFC_VEC_TMR2    10'h020

// ==========================================================
// Data memory map
`define CPFC_RAM_BASE    7'h40
`define CPFC_WR_PAGE     3'h7

// ==========================================================
// Instruction word fields
`define CPFC_OP_MSB      15
`define CPFC_OP_LSB      12
`define CPFC_STORE_BIT   11

// ==========================================================
// Opcodes
`define CPFC_OP_NOP      4'h0
`define CPFC_OP_JMP      4'h1
`define CPFC_OP_CALL     4'h2
`define CPFC_OP_RTS      4'h3
`define CPFC_OP_LDI      4'h4
`define CPFC_OP_LDM      4'h5
`define CPFC_OP_STM      4'h6
`define CPFC_OP_ADD      4'h7
`define CPFC_OP_ADC      4'h8
`define CPFC_OP_SUB      4'h9
`define CPFC_OP_SBC      4'ha
`define CPFC_OP_DAA      4'hb
`define CPFC_OP_DAS      4'hc
`define CPFC_OP_CTL      4'hd
`define CPFC_OP_WR       4'he
`define CPFC_OP_STOP     4'hf

// ==========================================================
// Control operand bits
`define CPFC_CTL_SETC    0
`define CPFC_CTL_CLRC    1
`define CPFC_CTL_EI      2
`define CPFC_CTL_DI      3
`define CPFC_CTL_SETB    4
`define CPFC_CTL_CLRB    5

// ==========================================================
// Reset values
`define CPFC_BCF_RST     1'b1
`define CPFC_SP_RST      2'h3

`endif

// File: rtl/cpfc_pkg.sv
/*
 Types shared by the program-flow core.
 Assumes nothing of its surroundings.
*/
package cpfc_pkg;

   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      ST_FETCH,
      ST_EXEC,
      ST_STOP
   } cpfc_state_type;

endpackage : cpfc_pkg

// File: rtl/cpfc_stack.sv
/*
 Four-entry wrap-around return stack.
 Assumes push and pop are never asked for in the same cycle.
*/
`timescale 1ns/100ps
`include "cpfc_defines.svh"

module cpfc_stack #(
   parameter int DEPTH = `CPFC_STK_DEPTH,
   parameter int W     = `CPFC_IP_W
) (
   input  wire logic         ref_clk_i,
   input  wire logic         reset_i,
   input  wire logic         push_i,
   input  wire logic         pop_i,
   input  wire logic [W-1:0] push_data_i,
   output logic      [W-1:0] top_o
);

   localparam int SPW = $clog2(DEPTH);

   logic [W-1:0]   entry_r [DEPTH];
   logic [SPW-1:0] sp_r;

   // ==========================================================
   // Pointer: no overflow flag, it simply wraps both ways
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sp_r <= SPW'(`CPFC_SP_RST);
      end else if (push_i) begin
         sp_r <= sp_r + 1'b1;
      end else if (pop_i) begin
         sp_r <= sp_r - 1'b1;
      end
   end

   // Entries: a push past four overwrites entry zero
   always_ff @(posedge ref_clk_i) begin
      if (push_i) begin
         entry_r[sp_r + 1'b1] <= push_data_i;
      end
   end

   // Top of stack read, entry three when empty
   assign top_o = entry_r[sp_r];

endmodule : cpfc_stack

// File: rtl/cpfc_dmem.sv
/*
 64 x 4 data memory at direct addresses 40h..7Fh.
 Assumes the core forms working-register addresses itself.
*/
`timescale 1ns/100ps
`include "cpfc_defines.svh"

module cpfc_dmem #(
   parameter int WORDS = `CPFC_RAM_WORDS
) (
   input  wire logic                     ref_clk_i,
   input  wire logic [`CPFC_DADDR_W-1:0] addr_i,
   input  wire logic                     we_i,
   input  wire logic [3:0]               wdata_i,
   output logic      [3:0]               rdata_o
);

   localparam int AW = $clog2(WORDS);

   logic [3:0] mem_r [WORDS];
   logic       hit;

   // Lower half of the direct space has no cells behind it
   assign hit = (addr_i >= `CPFC_RAM_BASE);

   always_ff @(posedge ref_clk_i) begin
      if (we_i && hit) begin
         mem_r[addr_i[AW-1:0]] <= wdata_i;
      end
   end

   // Unmapped reads return zero
   assign rdata_o = hit ? mem_r[addr_i[AW-1:0]] : 4'h0;

endmodule : cpfc_dmem

// File: rtl/cpfc_core.sv
/*
 Program-flow and datapath core of a 4-bit controller.
 Assumes a synchronous ROM with one cycle of read latency and
 interrupt and wake requests from logic on the same clock.
*/
// Operation
// - Instruction pointer is a 10-bit counter covering 1024 words.
// - Pointer advances by one after each executed instruction except jump, call and return.
// - Reset loads 000H, port A interrupt 014H, pre-divider 01CH.
// - Timer 2 interrupt loads the vector with only bit five set.
// - Jump and call load the pointer from operand bits nine to zero.
// - Call pushes the address after itself, interrupt entry the pointer, onto the stack.
// - Return loads pointer from stack top, then decrements stack pointer.
// - Stack holds four 10-bit entries with no overflow indication.
// - Push on a full stack wraps to entry zero and overwrites it.
// - Return on empty stack wraps to entry three and restores from it.
// - 64 nibbles answer at 40h..7Fh; 00h..3Fh reach no storage.
// - Locations 70H..7FH double as sixteen working registers.
// - Decimal adjust after add follows the carry and accumulator table.
// - Decimal adjust after subtract adds A modulo sixteen when needed.
// - Carry is an inverted borrow during subtraction.
// - Backup flag is set automatically before entering stop mode.
// - One oscillator fixed at manufacture, never switched.
// - Zero flag is one exactly when the accumulator is zero.
`timescale 1ns/100ps
`include "cpfc_defines.svh"

module cpfc_core #(
   parameter bit SLOW_ONLY = 1'b1
) (
   input  wire logic        ref_clk_i,
   input  wire logic        reset_i,
   output logic      [9:0]  rom_addr_o,
   output logic             rom_rd_o,
   input  wire logic [15:0] rom_data_i,
   input  wire logic        irq_porta_i,
   input  wire logic        irq_prediv_i,
   input  wire logic        irq_tmr2_i,
   input  wire logic        wake_i,
   output logic      [2:0]  irq_ack_o,
   output logic      [9:0]  instr_pointer_o,
   output logic      [3:0]  accum_o,
   output logic             carry_o,
   output logic             zero_o,
   output logic             int_en_o,
   output logic             osc_boost_flag_o,
   output logic             stop_o,
   output logic             slow_osc_en_o,
   output logic             fast_osc_en_o
);

   // ==========================================================
   // Declarations
   cpfc_pkg::cpfc_state_type state_r;

   logic [`CPFC_IP_W-1:0]    instr_pointer_r;
   logic [3:0]               accum_r;
   logic                     carry_r;
   logic                     zero_r;
   logic                     int_en_r;
   logic                     bcf_r;
   logic [2:0]               irq_ack_r;

   logic [3:0]               opcode;
   logic [`CPFC_IP_W-1:0]    operand_target;
   logic [7:0]               ctl;
   logic                     exec;
   logic                     take_irq;
   logic [`CPFC_IP_W-1:0]    irq_vector;
   logic [2:0]               irq_sel;

   logic [`CPFC_DADDR_W-1:0] mem_addr;
   logic                     mem_we;
   logic [3:0]               mem_rd;
   logic [3:0]               acc_nxt;
   logic                     carry_nxt;
   logic [4:0]               sum;

   logic                     stk_push;
   logic                     stk_pop;
   logic [`CPFC_IP_W-1:0]    stk_push_data;
   logic [`CPFC_IP_W-1:0]    stk_top;

   // ==========================================================
   // Helpers
   // Four-bit add with carry in, carry out in bit four
   function automatic logic [4:0] cpfc_add4(
      input logic [3:0] a,
      input logic [3:0] b,
      input logic       cin
   );
      cpfc_add4 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
   endfunction : cpfc_add4

   // ==========================================================
   // Instruction word fields
   assign opcode         = rom_data_i[`CPFC_OP_MSB:`CPFC_OP_LSB];
   assign operand_target = rom_data_i[`CPFC_IP_W-1:0];
   assign ctl            = rom_data_i[7:0];
   assign exec           = (state_r == cpfc_pkg::ST_EXEC);

   // Working-register ops address the top page of data memory
   always_comb begin
      if (opcode == `CPFC_OP_WR) begin
         mem_addr = {`CPFC_WR_PAGE, rom_data_i[3:0]};
      end else begin
         mem_addr = rom_data_i[`CPFC_DADDR_W-1:0];
      end
   end

   // ==========================================================
   // Interrupt selection
   // Fixed priority port A, then pre-divider, then timer 2
   always_comb begin
      irq_vector = `CPFC_VEC_PORTA;
      irq_sel    = 3'h0;
      if (irq_porta_i) begin
         irq_vector = `CPFC_VEC_PORTA;
         irq_sel    = 3'h1;
      end else if (irq_prediv_i) begin
         irq_vector = `CPFC_VEC_PREDIV;
         irq_sel    = 3'h2;
      end else if (irq_tmr2_i) begin
         irq_vector = `CPFC_VEC_TMR2;
         irq_sel    = 3'h4;
      end
   end

   // Only sampled in fetch, so never in the middle of an instruction
   assign take_irq = (state_r == cpfc_pkg::ST_FETCH) && int_en_r
                     && (irq_sel != 3'h0);

   // ==========================================================
   // Sequencer
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         state_r <= cpfc_pkg::ST_FETCH;
      end else begin
         case (state_r)
            cpfc_pkg::ST_FETCH: begin
               if (!take_irq) begin
                  state_r <= cpfc_pkg::ST_EXEC;
               end
            end
            cpfc_pkg::ST_EXEC: begin
               if (opcode == `CPFC_OP_STOP) begin
                  state_r <= cpfc_pkg::ST_STOP;
               end else begin
                  state_r <= cpfc_pkg::ST_FETCH;
               end
            end
            cpfc_pkg::ST_STOP: begin
               if (wake_i) begin
                  state_r <= cpfc_pkg::ST_FETCH;
               end
            end
            default: begin
               state_r <= cpfc_pkg::ST_FETCH;
            end
         endcase
      end
   end

   // ==========================================================
   // Instruction pointer
   // Pointer already names the next instruction when an interrupt
   // is taken in fetch, so that is the value saved.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         instr_pointer_r <= `CPFC_VEC_RESET;
      end else if (take_irq) begin
         instr_pointer_r <= irq_vector;
      end else if (exec) begin
         case (opcode)
            `CPFC_OP_JMP: begin
               instr_pointer_r <= operand_target;
            end
            `CPFC_OP_CALL: begin
               instr_pointer_r <= operand_target;
            end
            `CPFC_OP_RTS: begin
               instr_pointer_r <= stk_top;
            end
            default: begin
               instr_pointer_r <= instr_pointer_r + 1'b1;
            end
         endcase
      end
   end

   // ==========================================================
   // Return stack control
   assign stk_push = take_irq
                     || (exec && (opcode == `CPFC_OP_CALL));
   assign stk_pop  = exec && (opcode == `CPFC_OP_RTS);

   // Call saves the address after itself, interrupt the pointer
   always_comb begin
      if (take_irq) begin
         stk_push_data = instr_pointer_r;
      end else begin
         stk_push_data = instr_pointer_r + 1'b1;
      end
   end

   cpfc_stack #(
      .DEPTH (`CPFC_STK_DEPTH),
      .W     (`CPFC_IP_W)
   ) u_stack (
      .ref_clk_i   (ref_clk_i),
      .reset_i     (reset_i),
      .push_i      (stk_push),
      .pop_i       (stk_pop),
      .push_data_i (stk_push_data),
      .top_o       (stk_top)
   );

   // ==========================================================
   // Data memory
   cpfc_dmem #(
      .WORDS (`CPFC_RAM_WORDS)
   ) u_dmem (
      .ref_clk_i (ref_clk_i),
      .addr_i    (mem_addr),
      .we_i      (mem_we),
      .wdata_i   (acc_nxt),
      .rdata_o   (mem_rd)
   );

   // ==========================================================
   // Arithmetic and decimal adjust
   // Store bit writes the result back to the addressed cell too.
   always_comb begin
      acc_nxt   = accum_r;
      carry_nxt = carry_r;
      mem_we    = 1'b0;
      sum       = 5'h00;
      case (opcode)
         `CPFC_OP_LDI: begin
            acc_nxt = rom_data_i[3:0];
         end
         `CPFC_OP_LDM: begin
            acc_nxt = mem_rd;
         end
         `CPFC_OP_STM: begin
            mem_we = exec;
         end
         `CPFC_OP_ADD, `CPFC_OP_ADC: begin
            sum       = cpfc_add4(mem_rd, accum_r,
                                  (opcode == `CPFC_OP_ADC) & carry_r);
            acc_nxt   = sum[3:0];
            carry_nxt = sum[4];
            mem_we    = exec & rom_data_i[`CPFC_STORE_BIT];
         end
         `CPFC_OP_SUB, `CPFC_OP_SBC: begin
            // Memory minus accumulator, carry out one means no borrow
            sum       = cpfc_add4(mem_rd, ~accum_r,
                                  (opcode == `CPFC_OP_SUB) | carry_r);
            acc_nxt   = sum[3:0];
            carry_nxt = sum[4];
            mem_we    = exec & rom_data_i[`CPFC_STORE_BIT];
         end
         `CPFC_OP_DAA: begin
            if (!carry_r && (accum_r >= 4'ha)) begin
               acc_nxt   = accum_r + 4'h6;
               carry_nxt = 1'b1;
            end else if (carry_r && (accum_r <= 4'h3)) begin
               acc_nxt   = accum_r + 4'h6;
            end
            mem_we = exec & rom_data_i[`CPFC_STORE_BIT];
         end
         `CPFC_OP_DAS: begin
            // Adding A in four bits wraps modulo sixteen; carry kept
            if (!carry_r && (accum_r >= 4'h6)) begin
               acc_nxt = accum_r + 4'ha;
            end
            mem_we = exec & rom_data_i[`CPFC_STORE_BIT];
         end
         `CPFC_OP_CTL: begin
            if (ctl[`CPFC_CTL_SETC]) begin
               carry_nxt = 1'b1;
            end else if (ctl[`CPFC_CTL_CLRC]) begin
               carry_nxt = 1'b0;
            end
         end
         `CPFC_OP_WR: begin
            if (rom_data_i[`CPFC_STORE_BIT]) begin
               mem_we = exec;
            end else begin
               acc_nxt = mem_rd;
            end
         end
         default: begin
            acc_nxt = accum_r;
         end
      endcase
   end

   // ==========================================================
   // Accumulator, carry and zero flag
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         accum_r <= 4'h0;
         carry_r <= 1'b0;
         zero_r  <= 1'b1;
      end else if (exec) begin
         accum_r <= acc_nxt;
         carry_r <= carry_nxt;
         zero_r  <= (acc_nxt == 4'h0);
      end
   end

   // ==========================================================
   // Interrupt enable
   // Cleared on entry so a held request cannot re-enter at once
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         int_en_r <= 1'b0;
      end else if (take_irq) begin
         int_en_r <= 1'b0;
      end else if (exec && (opcode == `CPFC_OP_CTL)) begin
         if (ctl[`CPFC_CTL_EI]) begin
            int_en_r <= 1'b1;
         end else if (ctl[`CPFC_CTL_DI]) begin
            int_en_r <= 1'b0;
         end
      end
   end

   // Acknowledge names the source taken, one cycle wide
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         irq_ack_r <= 3'h0;
      end else begin
         irq_ack_r <= take_irq ? irq_sel : 3'h0;
      end
   end

   // ==========================================================
   // Oscillator backup flag
   // Set on reset and forced on the way into stop so the crystal
   // restarts with the extra drive; costs current until cleared.
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         bcf_r <= `CPFC_BCF_RST;
      end else if (exec && (opcode == `CPFC_OP_STOP)) begin
         bcf_r <= 1'b1;
      end else if (exec && (opcode == `CPFC_OP_CTL)) begin
         if (ctl[`CPFC_CTL_SETB]) begin
            bcf_r <= 1'b1;
         end else if (ctl[`CPFC_CTL_CLRB]) begin
            bcf_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign rom_addr_o       = instr_pointer_r;
   assign rom_rd_o         = (state_r == cpfc_pkg::ST_FETCH) && !take_irq;
   assign instr_pointer_o  = instr_pointer_r;
   assign accum_o          = accum_r;
   assign carry_o          = carry_r;
   assign zero_o           = zero_r;
   assign int_en_o         = int_en_r;
   assign irq_ack_o        = irq_ack_r;
   assign osc_boost_flag_o = bcf_r;
   assign stop_o           = (state_r == cpfc_pkg::ST_STOP);

   // Oscillator choice is a mask option: a constant, never toggled
   assign slow_osc_en_o    = SLOW_ONLY;
   assign fast_osc_en_o    = !SLOW_ONLY;

endmodule : cpfc_core

// File: tb/cpfc_core_checker.sv
/*
 Concurrent checks on the ports of the program-flow core.
 Assumes it is bound to cpfc_core and sees only that module's ports.
*/
`timescale 1ns/100ps

module cpfc_core_checker #(
   parameter bit SLOW_ONLY = 1'b1
) (
   input wire logic        ref_clk_i,
   input wire logic        reset_i,
   input wire logic [9:0]  rom_addr_o,
   input wire logic        rom_rd_o,
   input wire logic [15:0] rom_data_i,
   input wire logic        irq_porta_i,
   input wire logic        irq_prediv_i,
   input wire logic        irq_tmr2_i,
   input wire logic        wake_i,
   input wire logic [2:0]  irq_ack_o,
   input wire logic [9:0]  instr_pointer_o,
   input wire logic [3:0]  accum_o,
   input wire logic        carry_o,
   input wire logic        zero_o,
   input wire logic        int_en_o,
   input wire logic        osc_boost_flag_o,
   input wire logic        stop_o,
   input wire logic        slow_osc_en_o,
   input wire logic        fast_osc_en_o
);
   logic [9:0] target;

   // ====================
   // Jump target field, kept apart so that $past sees a plain signal
   assign target = rom_data_i[9:0];

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);

   // ====================
   // Steps: a fetch followed by the execute cycle of a given opcode, entry into stop, and a wake while stopped
   sequence exec_s(logic [3:0] op);
      rom_rd_o ##1 rom_data_i[15:12] == op;
   endsequence
   sequence stop_entry_s;
      !stop_o ##1 stop_o;
   endsequence
   sequence wake_s;
      stop_o && wake_i;
   endsequence

   // ====================
   // Checks
   reset_load_a: assert property (disable iff (1'b0) reset_i |=>
      instr_pointer_o == 10'h000 && accum_o == 4'h0 && osc_boost_flag_o && !int_en_o)
      else $error("reset did not load the start state");
   zero_track_a: assert property (zero_o == (accum_o == 4'h0))
      else $error("zero flag disagrees with accumulator");
   porta_vec_a: assert property (irq_ack_o == 3'b001 |-> instr_pointer_o == 10'h014)
      else $error("port A vector wrong");
   prediv_vec_a: assert property (irq_ack_o == 3'b010 |->
      instr_pointer_o == 10'h01c && !$past(irq_porta_i)) else $error("pre-divider vector wrong");
   tmr2_vec_a: assert property (irq_ack_o == 3'b100 |-> instr_pointer_o == 10'h020)
      else $error("timer 2 vector wrong");
   ack_cause_a: assert property (irq_ack_o != 3'h0 |->
      $past(int_en_o) && !$past(rom_rd_o) ##1 irq_ack_o == 3'h0) else $error("bad interrupt take");
   stop_boost_a: assert property (stop_entry_s |-> osc_boost_flag_o)
      else $error("backup flag not set on stop entry");
   stop_hold_a: assert property (stop_o && !wake_i |=>
      stop_o && !rom_rd_o && $stable(instr_pointer_o)) else $error("pointer moved in stop");
   wake_exit_a: assert property (wake_s |=> !stop_o)
      else $error("wake did not leave stop");
   one_osc_a: assert property (slow_osc_en_o == SLOW_ONLY && fast_osc_en_o == !SLOW_ONLY)
      else $error("oscillator selection changed");
   addr_ptr_a: assert property (rom_rd_o |=>
      $stable(rom_addr_o) && rom_addr_o == instr_pointer_o) else $error("fetch address moved");
   ptr_step_a: assert property (exec_s(4'h0) |=>
      instr_pointer_o == $past(instr_pointer_o) + 10'h001) else $error("pointer did not step");
   jump_load_a: assert property (exec_s(4'h1) |=> instr_pointer_o == $past(target))
      else $error("jump target not loaded");
endmodule : cpfc_core_checker

bind cpfc_core cpfc_core_checker #(.SLOW_ONLY(SLOW_ONLY)) u_chk (.ref_clk_i, .reset_i,
   .rom_addr_o, .rom_rd_o, .rom_data_i, .irq_porta_i, .irq_prediv_i, .irq_tmr2_i, .wake_i,
   .irq_ack_o, .instr_pointer_o, .accum_o, .carry_o, .zero_o, .int_en_o, .osc_boost_flag_o,
   .stop_o, .slow_osc_en_o, .fast_osc_en_o);

// File: tb/cpfc_rom_model.sv
/*
 Behavioural instruction ROM, 1024 x 16, one cycle of read latency.
 Assumes the bench loads mem directly while the core is held in reset.
*/
`timescale 1ns/100ps

module cpfc_rom_model (
   input  wire logic        ref_clk_i,
   input  wire logic [9:0]  rom_addr_i,
   input  wire logic        rom_rd_i,
   output logic      [15:0] rom_data_o
);
   logic [15:0] mem [1024];

   // ====================
   // Read port; without a strobe the word toggles so stale reads show up
   always_ff @(posedge ref_clk_i) begin
      if (rom_rd_i) begin
         rom_data_o <= mem[rom_addr_i];
      end else begin
         rom_data_o <= ~rom_data_o;
      end
   end
endmodule : cpfc_rom_model

// File: tb/test_cpfc_program_flow_core.sv
/*
 Self-checking bench for the program-flow core with a ROM model.
 Assumes a 20 MHz clock and the opcode map of the core's hand-over.
*/
`timescale 1ns/100ps

module test_cpfc_program_flow_core;
   logic        ref_clk_i, reset_i, rom_rd_o, wake_i;
   logic        irq_porta_i, irq_prediv_i, irq_tmr2_i, carry_o, zero_o, int_en_o;
   logic        osc_boost_flag_o, stop_o, slow_osc_en_o, fast_osc_en_o;
   logic [9:0]  rom_addr_o, instr_pointer_o;
   logic [15:0] rom_data_i;
   logic [3:0]  accum_o;
   logic [2:0]  irq_ack_o;
   int          err_count = 0;
   int          n_compared = 0;
   logic [9:0]  fq[$];

   cpfc_core #(.SLOW_ONLY(1'b1)) DUT (.ref_clk_i, .reset_i, .rom_addr_o, .rom_rd_o,
      .rom_data_i, .irq_porta_i, .irq_prediv_i, .irq_tmr2_i, .wake_i, .irq_ack_o,
      .instr_pointer_o, .accum_o, .carry_o, .zero_o, .int_en_o, .osc_boost_flag_o,
      .stop_o, .slow_osc_en_o, .fast_osc_en_o);
   cpfc_rom_model ROM (.ref_clk_i(ref_clk_i), .rom_addr_i(rom_addr_o), .rom_rd_i(rom_rd_o),
      .rom_data_o(rom_data_i));

   // ====================
   // Clock, 50 ns period
   initial begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   // Fetch trace; every fetched address shows the program's path
   always @(posedge ref_clk_i) begin
      if (!reset_i && rom_rd_o) fq.push_back(rom_addr_o);
   end

   // ====================
   // Helpers
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk_i);
      #2;
   endtask : step

   task automatic hold_reset();
      reset_i = 1'b1;
      {irq_tmr2_i, irq_prediv_i, irq_porta_i, wake_i} = 4'h0;
      foreach (ROM.mem[i]) ROM.mem[i] = 16'h0000;
      step(2);
   endtask : hold_reset

   task automatic put(input logic [9:0] a, input logic [3:0] op, input logic [11:0] arg);
      ROM.mem[a] = {op, arg};
   endtask : put

   // Program from address zero upwards
   task automatic load(input logic [15:0] w[$]);
      foreach (w[i]) ROM.mem[i] = w[i];
   endtask : load

   task automatic run(input int n);
      fq.delete();
      reset_i = 1'b0;
      step(n);
   endtask : run

   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_trace(input logic [9:0] exp[$]);
      foreach (exp[i]) chk_val((i < fq.size()) ? {6'h0, fq[i]} : 16'hxxxx, {6'h0, exp[i]},
         "fetch order");
   endtask : chk_trace

   // ====================
   // Scenarios
   task automatic test_reset();
      hold_reset();
      chk_val({6'h0, instr_pointer_o}, 16'h0000, "reset pointer");
      chk_val({4'h0, accum_o, carry_o, zero_o, osc_boost_flag_o, int_en_o, stop_o, irq_ack_o},
         16'h0060, "reset flags");
      chk_val({14'h0, slow_osc_en_o, fast_osc_en_o}, 16'h0002, "oscillator pick");
      $display("test reset done");
   endtask : test_reset

   task automatic test_daa();
      hold_reset();
      load('{16'hd002, 16'h4009, 16'h6040, 16'h4001, 16'h7040, 16'hb000, 16'hb000,
         16'h1007});
      run(24);
      chk_trace('{10'h0, 10'h1, 10'h2, 10'h3, 10'h4, 10'h5, 10'h6, 10'h7, 10'h7});
      chk_val({11'h0, accum_o, carry_o}, 16'h000d, "decimal add");
      $display("test decimal add done");
   endtask : test_daa

   task automatic test_das();
      hold_reset();
      load('{16'hd001, 16'h4001, 16'h6041, 16'h4002, 16'h9041, 16'hc000, 16'h1006});
      run(20);
      chk_val({10'h0, accum_o, carry_o, zero_o}, 16'h0024, "decimal sub");
      $display("test decimal sub done");
   endtask : test_das

   task automatic test_mem();
      hold_reset();
      load('{16'h4005, 16'h603f, 16'h4007, 16'h6075, 16'h4003, 16'he802, 16'he005,
         16'h703f, 16'h7072, 16'h1009});
      run(26);
      chk_val({11'h0, accum_o, carry_o}, 16'h0014, "memory views");
      $display("test memory done");
   endtask : test_mem

   task automatic test_stack();
      hold_reset();
      put(10'h000, 4'h2, 12'h100);
      put(10'h100, 4'h2, 12'h200);
      put(10'h200, 4'h2, 12'h300);
      put(10'h300, 4'h2, 12'h380);
      put(10'h380, 4'h2, 12'h3c0);
      put(10'h3c0, 4'h3, 12'h000);
      put(10'h381, 4'h3, 12'h000);
      put(10'h301, 4'h3, 12'h000);
      put(10'h201, 4'h3, 12'h000);
      put(10'h101, 4'h3, 12'h000);
      run(30);
      chk_trace('{10'h000, 10'h100, 10'h200, 10'h300, 10'h380, 10'h3c0, 10'h381, 10'h301,
         10'h201, 10'h101, 10'h381, 10'h301});
      $display("test stack done");
   endtask : test_stack

   task automatic test_irq(input logic [2:0] req, input logic [2:0] ack, input logic [9:0] vec);
      hold_reset();
      load('{16'hd004, 16'h1001});
      put(10'h014, 4'h3, 12'h000);
      put(10'h01c, 4'h3, 12'h000);
      put(10'h020, 4'h3, 12'h000);
      run(4);
      {irq_tmr2_i, irq_prediv_i, irq_porta_i} = req;
      for (int i = 0; i < 20 && irq_ack_o === 3'h0; i++) step(1);
      chk_val({13'h0, irq_ack_o}, {13'h0, ack}, "interrupt source");
      chk_val({5'h0, int_en_o, instr_pointer_o}, {6'h0, vec}, "interrupt vector");
      {irq_tmr2_i, irq_prediv_i, irq_porta_i} = 3'h0;
      step(10);
      chk_val({6'h0, instr_pointer_o}, 16'h0001, "return point");
      $display("test interrupt %b done", req);
   endtask : test_irq

   task automatic test_stop();
      hold_reset();
      load('{16'hd020, 16'hf000, 16'h0000, 16'h1003});
      run(3);
      chk_val({15'h0, osc_boost_flag_o}, 16'h0000, "flag cleared");
      for (int i = 0; i < 20 && stop_o !== 1'b1; i++) step(1);
      chk_val({15'h0, osc_boost_flag_o}, 16'h0001, "flag at stop");
      step(5);
      chk_val({15'h0, stop_o}, 16'h0001, "stop holds");
      wake_i = 1'b1;
      step(1);
      wake_i = 1'b0;
      step(6);
      chk_val({5'h0, stop_o, instr_pointer_o}, 16'h0003, "after wake");
      $display("test stop done");
   endtask : test_stop

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : summarize

   // ====================
   // Watchdog: the scenarios need well under a thousand cycles
   initial begin
      repeat (4000) @(posedge ref_clk_i);
      err_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      summarize();
   end

   // Main sequence
   initial begin
      test_reset();
      test_daa();
      test_das();
      test_mem();
      test_stack();
      test_irq(3'b001, 3'b001, 10'h014);
      test_irq(3'b010, 3'b010, 10'h01c);
      test_irq(3'b100, 3'b100, 10'h020);
      test_irq(3'b011, 3'b001, 10'h014);
      test_stop();
      summarize();
   end
endmodule : test_cpfc_program_flow_core
